// ---- pkg/rbs_consts.vh ----
// Constants for the reset and boot strap select block
// Operation
// - Holding the reset pin low keeps the core in hardware reset.
// - The reset pin has an internal pull-up so an undriven pin lets the device run.
// - Boot straps 01 or 11 select flash boot and 10 selects download boot.
// - With both debug fuses clear and selection allowed, debug strap 0 picks pins and 1 picks USB.
// - With debug selection not allowed, the debug strap is ignored and USB is used.
`ifndef RBS_CONSTS_VH
`define RBS_CONSTS_VH

// Register byte offsets
`define RBS_ADDR_CTRL 8'h00
`define RBS_ADDR_STATUS 8'h04
`define RBS_ADDR_CAUSE 8'h08
`define RBS_ADDR_COUNT 8'h0C
`define RBS_ADDR_SCRATCH 8'h10
`define RBS_ADDR_LIVE 8'h14

// Control fields
`define RBS_CTRL_REBOOT 0
`define RBS_CTRL_HOLD 1

// Cause fields
`define RBS_CAUSE_PIN 0
`define RBS_CAUSE_SOFT 1
`define RBS_CAUSE_POWER 2
`define RBS_CAUSE_W 3

// Status fields
`define RBS_ST_BOOT_LO 0
`define RBS_ST_DBG_STRAP 2
`define RBS_ST_DOWNLOAD 3
`define RBS_ST_FROM_USB 4
`define RBS_ST_PIN_EN 5
`define RBS_ST_USB_EN 6
`define RBS_ST_BAD 7
`define RBS_ST_FUSE_LO 8
`define RBS_ST_IN_RESET 11

// Boot strap patterns
`define RBS_BOOT_DOWNLOAD 2'b10
`define RBS_BOOT_BAD 2'b00
`define RBS_BOOT_RESET 2'b11

// Reset value and counter width
`define RBS_SCRATCH_RESET 32'h00000000
`define RBS_COUNT_W 16

// Timing
`define RBS_CLK_NS 20
`define RBS_HOLD_NS 1000
`define RBS_HOLD_CYC ((`RBS_HOLD_NS + `RBS_CLK_NS - 1) / `RBS_CLK_NS)

`endif

// ---- hw/rbs_reset_gen.v ----
// Core reset generator with release stretch
`timescale 1ns/1ps
`include "rbs_consts.vh"
module rbs_reset_gen #(
    parameter CW = 16,
    parameter [CW-1:0] HOLD = `RBS_HOLD_CYC
) (
    input wire clk, // System clock
    input wire nrst, // Synchronous reset, active low
    input wire trig, // Any reset request level or pulse
    output reg core_rst_n, // Core reset, active low
    output reg release_pulse // One cycle at core release
);
    reg [CW-1:0] cnt;

    // Any request restarts the stretch; release only after HOLD quiet cycles
    always @(posedge clk) begin
        if (!nrst) begin
            cnt <= {CW{1'b0}};
            core_rst_n <= 1'b0;
            release_pulse <= 1'b0;
        end else if (trig) begin
            cnt <= {CW{1'b0}};
            core_rst_n <= 1'b0;
            release_pulse <= 1'b0;
        end else if (cnt != HOLD) begin
            cnt <= cnt + 1'b1;
            release_pulse <= 1'b0;
        end else begin
            release_pulse <= !core_rst_n;
            core_rst_n <= 1'b1;
        end
    end
endmodule // rbs_reset_gen

// ---- hw/rbs_strap_latch.v ----
// Strap capture and boot and debug source decode
`timescale 1ns/1ps
`include "rbs_consts.vh"
module rbs_strap_latch (
    input wire clk, // System clock
    input wire nrst, // Synchronous reset, active low
    input wire capture, // One cycle at core release
    input wire boot_strap_a, // Boot strap, low bit
    input wire boot_strap_b, // Boot strap, high bit
    input wire debug_source_strap, // Debug source strap
    input wire fuse_usb_debug_off, // Fuse: USB debug disabled
    input wire fuse_pin_debug_off, // Fuse: pin debug disabled
    input wire fuse_debug_select_allow, // Fuse: strap may pick debug source
    output reg [1:0] boot_pat, // Latched boot pattern
    output reg dbg_pat, // Latched debug strap
    output reg download, // Download boot selected
    output reg bad, // Invalid boot pattern seen
    output reg from_usb, // Debug routed from USB controller
    output reg pin_en, // Pin debug enabled
    output reg usb_en // USB debug enabled
);
    wire [1:0] pat = {boot_strap_b, boot_strap_a};
    // Strap only counts when selection is allowed by fuse
    wire sel_pin = fuse_debug_select_allow & !debug_source_strap;

    // Sampled once per release, held through any core reset until the next release or NRST
    always @(posedge clk) begin
        if (!nrst) begin
            boot_pat <= `RBS_BOOT_RESET;
            dbg_pat <= 1'b0;
            download <= 1'b0;
            bad <= 1'b0;
            from_usb <= 1'b1;
            pin_en <= 1'b0;
            usb_en <= 1'b0;
        end else if (capture) begin
            boot_pat <= pat;
            dbg_pat <= debug_source_strap;
            download <= (pat == `RBS_BOOT_DOWNLOAD);
            bad <= (pat == `RBS_BOOT_BAD);
            from_usb <= !sel_pin;
            pin_en <= sel_pin & !fuse_pin_debug_off;
            usb_en <= !sel_pin & !fuse_usb_debug_off;
        end
    end
endmodule // rbs_strap_latch

// ---- hw/rbs_top.v ----
// Reset and boot strap select block with AHB-Lite registers
`timescale 1ns/1ps
`include "rbs_consts.vh"
module rbs_top #(
    parameter CW = 16,
    parameter [CW-1:0] HOLD = `RBS_HOLD_CYC
) (
    input wire SYS_CLK, // 50 MHz system clock
    input wire NRST, // Synchronous power-on reset, active low
    input wire RESET_PIN_N, // Reset pad level, active low
    output reg RESET_PULLUP_EN, // Internal pull-up on reset pad
    input wire BOOT_STRAP_A, // Boot strap low bit
    input wire BOOT_STRAP_B, // Boot strap high bit
    input wire DEBUG_SOURCE_STRAP, // Debug source strap
    input wire FUSE_USB_DEBUG_OFF, // Fuse level
    input wire FUSE_PIN_DEBUG_OFF, // Fuse level
    input wire FUSE_DEBUG_SELECT_ALLOW, // Fuse level
    output wire CORE_RST_N, // Core reset, active low
    output wire BOOT_DOWNLOAD, // High for download boot
    output wire DEBUG_FROM_USB, // High when debug comes from USB
    output wire PIN_DEBUG_EN, // Pin debug port enabled
    output wire USB_DEBUG_EN, // USB debug port enabled
    input wire HSEL, // AHB slave select
    input wire [31:0] HADDR, // AHB address
    input wire [1:0] HTRANS, // AHB transfer type
    input wire HWRITE, // AHB write
    input wire [2:0] HSIZE, // AHB size
    input wire [31:0] HWDATA, // AHB write data
    input wire HREADY, // AHB bus ready
    output reg HREADYOUT, // Slave ready
    output reg HRESP, // Slave response
    output reg [31:0] HRDATA // Read data
);
    // Registered pad samples
    reg pin_low;
    reg [2:0] live;

    // Control and bookkeeping state
    reg ctrl_hold;
    reg reboot_req;
    reg [`RBS_CAUSE_W-1:0] cause;
    reg [`RBS_COUNT_W-1:0] boot_count;
    reg [31:0] scratch;

    // Write data phase bookkeeping
    reg wr_pend;
    reg [7:0] wr_addr;

    // Decode outputs
    wire [1:0] boot_pat;
    wire dbg_pat;
    wire strap_bad;
    wire release_pulse;
    wire trig;
    wire take;
    wire [31:0] status_word;
    reg [31:0] next_rdata;

    // Word-sized transfer check, used for both reads and writes
    function word_access;
        input [2:0] size;
        input [1:0] low;
        begin
            word_access = (size == 3'b010) && (low == 2'b00);
        end
    endfunction

    // Pull-up always enabled so a floating pin reads high
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            RESET_PULLUP_EN <= 1'b1;
        end else begin
            RESET_PULLUP_EN <= 1'b1;
        end
    end

    // Pad sample; pin_low resets to 0, matching the pulled-up idle pin
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            pin_low <= 1'b0;
            live <= 3'h0;
        end else begin
            pin_low <= !RESET_PIN_N;
            live <= {DEBUG_SOURCE_STRAP, BOOT_STRAP_B, BOOT_STRAP_A};
        end
    end

    // Pin low, software reboot or software hold all reset the core
    assign trig = pin_low | reboot_req | ctrl_hold;

    rbs_reset_gen #(
        .CW(CW),
        .HOLD(HOLD)
    ) u_reset (
        .clk(SYS_CLK),
        .nrst(NRST),
        .trig(trig),
        .core_rst_n(CORE_RST_N),
        .release_pulse(release_pulse)
    );

    // Straps latched on the release pulse only
    rbs_strap_latch u_strap (
        .clk(SYS_CLK),
        .nrst(NRST),
        .capture(release_pulse),
        .boot_strap_a(BOOT_STRAP_A),
        .boot_strap_b(BOOT_STRAP_B),
        .debug_source_strap(DEBUG_SOURCE_STRAP),
        .fuse_usb_debug_off(FUSE_USB_DEBUG_OFF),
        .fuse_pin_debug_off(FUSE_PIN_DEBUG_OFF),
        .fuse_debug_select_allow(FUSE_DEBUG_SELECT_ALLOW),
        .boot_pat(boot_pat),
        .dbg_pat(dbg_pat),
        .download(BOOT_DOWNLOAD),
        .bad(strap_bad),
        .from_usb(DEBUG_FROM_USB),
        .pin_en(PIN_DEBUG_EN),
        .usb_en(USB_DEBUG_EN)
    );

    // Address phase accepted on a selected active transfer
    assign take = HSEL & HREADY & HTRANS[1];

    // Status view of the latched selection and fuses
    assign status_word = {20'h00000,
                          !CORE_RST_N,
                          FUSE_DEBUG_SELECT_ALLOW,
                          FUSE_PIN_DEBUG_OFF,
                          FUSE_USB_DEBUG_OFF,
                          strap_bad,
                          USB_DEBUG_EN,
                          PIN_DEBUG_EN,
                          DEBUG_FROM_USB,
                          BOOT_DOWNLOAD,
                          dbg_pat,
                          boot_pat};

    // Read mux; unmapped offsets and odd sizes read as zero
    always @* begin
        next_rdata = 32'h00000000;
        if (word_access(HSIZE, HADDR[1:0])) begin
            case (HADDR[7:0])
                `RBS_ADDR_CTRL: begin
                    next_rdata = {30'h0000000, ctrl_hold, 1'b0};
                end
                `RBS_ADDR_STATUS: begin
                    next_rdata = status_word;
                end
                `RBS_ADDR_CAUSE: begin
                    next_rdata = {29'h0000000, cause};
                end
                `RBS_ADDR_COUNT: begin
                    next_rdata = {16'h0000, boot_count};
                end
                `RBS_ADDR_SCRATCH: begin
                    next_rdata = scratch;
                end
                `RBS_ADDR_LIVE: begin
                    next_rdata = {29'h0000000, live};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Zero wait state slave, always OKAY
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            if (take && !HWRITE) begin
                HRDATA <= next_rdata;
            end else begin
                HRDATA <= 32'h00000000;
            end
        end
    end

    // Capture write address; data arrives one cycle later
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take & HWRITE & word_access(HSIZE, HADDR[1:0]);
            wr_addr <= HADDR[7:0];
        end
    end

    // Control register; reboot bit self-clears after one cycle
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_hold <= 1'b0;
            reboot_req <= 1'b0;
            scratch <= `RBS_SCRATCH_RESET;
        end else begin
            reboot_req <= 1'b0;
            if (wr_pend && wr_addr == `RBS_ADDR_CTRL) begin
                ctrl_hold <= HWDATA[`RBS_CTRL_HOLD];
                reboot_req <= HWDATA[`RBS_CTRL_REBOOT];
            end
            if (wr_pend && wr_addr == `RBS_ADDR_SCRATCH) begin
                scratch <= HWDATA;
            end
        end
    end

    // Sticky cause bits, write one to clear, a new event wins over clear
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            cause <= 3'h4;
        end else begin
            if (wr_pend && wr_addr == `RBS_ADDR_CAUSE) begin
                cause <= (cause & ~HWDATA[2:0]) | {1'b0, reboot_req, pin_low};
            end else begin
                cause <= cause | {1'b0, reboot_req, pin_low};
            end
        end
    end

    // Release counter; wraps, counts every core release
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            boot_count <= 16'h0000;
        end else if (release_pulse) begin
            boot_count <= boot_count + 1'b1;
        end
    end
endmodule // rbs_top

// ---- bench/rbs_props.sv ----
// Checker for pin reset, strap decode and strap hold
`timescale 1ns/1ps
module rbs_props #(
    parameter CW = 16,
    parameter [CW-1:0] HOLD = 16'h0032
) (
    input logic SYS_CLK, // Clock
    input logic NRST, // Reset, active low
    input logic RESET_PIN_N, // Reset pad
    input logic RESET_PULLUP_EN, // Pad pull-up
    input logic BOOT_STRAP_A, // Boot strap low
    input logic BOOT_STRAP_B, // Boot strap high
    input logic DEBUG_SOURCE_STRAP, // Debug strap
    input logic FUSE_USB_DEBUG_OFF, // Fuse
    input logic FUSE_PIN_DEBUG_OFF, // Fuse
    input logic FUSE_DEBUG_SELECT_ALLOW, // Fuse
    input logic CORE_RST_N, // Core reset
    input logic BOOT_DOWNLOAD, // Download boot
    input logic DEBUG_FROM_USB, // Debug from USB
    input logic PIN_DEBUG_EN, // Pin debug on
    input logic USB_DEBUG_EN // USB debug on
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // Strap picks the pins only when the fuse allows it
    wire pick_pin = FUSE_DEBUG_SELECT_ALLOW && !DEBUG_SOURCE_STRAP;

    chk_pin_reset: assert property (!RESET_PIN_N |-> ##[1:2] !CORE_RST_N)
        else $error("core not reset by pad");
    chk_reset_stretch: assert property ($rose(RESET_PIN_N) |-> !CORE_RST_N [*4] ##[1:8] CORE_RST_N)
        else $error("core release stretch wrong");
    chk_pullup_on: assert property (RESET_PULLUP_EN)
        else $error("pad pull-up off");
    chk_boot_decode: assert property ($rose(CORE_RST_N) |=>
        BOOT_DOWNLOAD == ($past(BOOT_STRAP_B) && !$past(BOOT_STRAP_A)))
        else $error("boot mode decode wrong");
    chk_debug_route: assert property ($rose(CORE_RST_N) |=> DEBUG_FROM_USB == !$past(pick_pin))
        else $error("debug source wrong");
    chk_pin_enable: assert property ($rose(CORE_RST_N) |=>
        PIN_DEBUG_EN == ($past(pick_pin) && !$past(FUSE_PIN_DEBUG_OFF)))
        else $error("pin debug enable wrong");
    chk_usb_enable: assert property ($rose(CORE_RST_N) |=>
        USB_DEBUG_EN == (!$past(pick_pin) && !$past(FUSE_USB_DEBUG_OFF)))
        else $error("usb debug enable wrong");
    chk_choice_held: assert property (CORE_RST_N && $past(CORE_RST_N) && $past(CORE_RST_N, 2) |->
        $stable(BOOT_DOWNLOAD) && $stable(DEBUG_FROM_USB) && $stable(PIN_DEBUG_EN) && $stable(USB_DEBUG_EN))
        else $error("latched choice changed while running");
endmodule // rbs_props

bind rbs_top rbs_props #(.CW(CW), .HOLD(HOLD)) u_props (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .RESET_PIN_N(RESET_PIN_N), .RESET_PULLUP_EN(RESET_PULLUP_EN), .BOOT_STRAP_A(BOOT_STRAP_A),
    .BOOT_STRAP_B(BOOT_STRAP_B), .DEBUG_SOURCE_STRAP(DEBUG_SOURCE_STRAP), .FUSE_USB_DEBUG_OFF(FUSE_USB_DEBUG_OFF),
    .FUSE_PIN_DEBUG_OFF(FUSE_PIN_DEBUG_OFF), .FUSE_DEBUG_SELECT_ALLOW(FUSE_DEBUG_SELECT_ALLOW),
    .CORE_RST_N(CORE_RST_N), .BOOT_DOWNLOAD(BOOT_DOWNLOAD), .DEBUG_FROM_USB(DEBUG_FROM_USB),
    .PIN_DEBUG_EN(PIN_DEBUG_EN), .USB_DEBUG_EN(USB_DEBUG_EN));

// ---- bench/rbs_board.sv ----
// Board strap resistors and open-drain reset driver
`timescale 1ns/1ps
module rbs_board (
    input logic clk, // Clock
    input logic pull, // Pull reset pad low
    input logic [1:0] pat_req, // Wanted boot pattern {b, a}
    input logic dbg_req, // Wanted debug strap
    input logic pullup_en, // Device pull-up on pad
    output logic pin_n, // Reset pad level
    output logic strap_a, // Boot strap low
    output logic strap_b, // Boot strap high
    output logic dbg_strap // Debug strap
);
    logic alt = 1'h0;
    // A floating pad must not look like a clean level
    always @(posedge clk) alt <= ~alt;
    // Open drain: pulled low or released, never driven high
    assign pin_n = pull ? 1'h0 : (pullup_en ? 1'h1 : alt);
    // The resistor network never fits the invalid pattern
    assign {strap_b, strap_a} = (pat_req == 2'h0) ? 2'h3 : pat_req;
    assign dbg_strap = dbg_req;
endmodule // rbs_board

// ---- bench/rbs_top_test.sv ----
// Self-checking bench for the reset and boot strap block
`timescale 1ns/1ps
module rbs_top_test;
    logic SYS_CLK = 1'h0;
    logic NRST = 1'h0;
    logic FUSE_USB_DEBUG_OFF = 1'h0, FUSE_PIN_DEBUG_OFF = 1'h0, FUSE_DEBUG_SELECT_ALLOW = 1'h1;
    logic HSEL = 1'h0, HWRITE = 1'h0, pull = 1'h1, dbg_req = 1'h0, ds;
    logic [1:0] HTRANS = 2'h0, pat_req = 2'h3, bp;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd, wv;
    logic [3:0] e;
    logic [1:0] pats [3] = '{2'h1, 2'h2, 2'h3};
    wire RESET_PIN_N, RESET_PULLUP_EN, BOOT_STRAP_A, BOOT_STRAP_B, DEBUG_SOURCE_STRAP, CORE_RST_N;
    wire BOOT_DOWNLOAD, DEBUG_FROM_USB, PIN_DEBUG_EN, USB_DEBUG_EN, HREADYOUT, HRESP;
    wire [31:0] HRDATA;
    wire HREADY = HREADYOUT; // Lone slave drives bus ready
    int err_total = 0;
    int checks = 0;

    always #10 SYS_CLK = ~SYS_CLK;

    rbs_top #(.CW(16), .HOLD(16'h0004)) dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .RESET_PIN_N(RESET_PIN_N),
        .RESET_PULLUP_EN(RESET_PULLUP_EN), .BOOT_STRAP_A(BOOT_STRAP_A), .BOOT_STRAP_B(BOOT_STRAP_B),
        .DEBUG_SOURCE_STRAP(DEBUG_SOURCE_STRAP), .FUSE_USB_DEBUG_OFF(FUSE_USB_DEBUG_OFF),
        .FUSE_PIN_DEBUG_OFF(FUSE_PIN_DEBUG_OFF), .FUSE_DEBUG_SELECT_ALLOW(FUSE_DEBUG_SELECT_ALLOW),
        .CORE_RST_N(CORE_RST_N), .BOOT_DOWNLOAD(BOOT_DOWNLOAD), .DEBUG_FROM_USB(DEBUG_FROM_USB),
        .PIN_DEBUG_EN(PIN_DEBUG_EN), .USB_DEBUG_EN(USB_DEBUG_EN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .HRDATA(HRDATA));
    rbs_board board (.clk(SYS_CLK), .pull(pull), .pat_req(pat_req), .dbg_req(dbg_req),
        .pullup_en(RESET_PULLUP_EN), .pin_n(RESET_PIN_N), .strap_a(BOOT_STRAP_A), .strap_b(BOOT_STRAP_B),
        .dbg_strap(DEBUG_SOURCE_STRAP));

    // Expected {download, debug from usb, pin debug, usb debug}
    function automatic logic [3:0] expect_out(input logic [1:0] p, input logic d, uo, po, al);
        logic sel;
        sel = al & ~d;
        return {p == 2'h2, ~sel, sel & ~po, ~sel & ~uo};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One single word transfer; address phase held until ready seen
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
        r = HRDATA;
        check(HRESP, 32'h0);
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (8000) @(posedge SYS_CLK);
        err_total++;
        report_and_stop;
    end

    initial begin
        void'($urandom(21456));
        repeat (6) @(posedge SYS_CLK);
        NRST <= 1'h1;
        // First twelve boots walk every valid pattern (01, 10, 11), strap and allow value
        for (int i = 0; i < 24; i++) begin
            bp = (i < 12) ? pats[i % 3] : pats[$urandom_range(2)];
            ds = (i < 12) ? 1'((i / 3) % 2) : 1'($urandom_range(1));
            pull <= 1'h1;
            pat_req <= bp;
            dbg_req <= ds;
            FUSE_DEBUG_SELECT_ALLOW <= (i < 12) ? 1'(i / 6) : 1'($urandom_range(1));
            FUSE_USB_DEBUG_OFF <= 1'($urandom_range(1));
            FUSE_PIN_DEBUG_OFF <= 1'($urandom_range(1));
            repeat (3 + $urandom_range(5)) @(posedge SYS_CLK);
            check(CORE_RST_N, 32'h0);
            pull <= 1'h0;
            repeat (10) @(posedge SYS_CLK);
            check(CORE_RST_N, 32'h1);
            check(RESET_PULLUP_EN, 32'h1);
            e = expect_out(bp, ds, FUSE_USB_DEBUG_OFF, FUSE_PIN_DEBUG_OFF, FUSE_DEBUG_SELECT_ALLOW);
            check({BOOT_DOWNLOAD, DEBUG_FROM_USB, PIN_DEBUG_EN, USB_DEBUG_EN}, e);
            // Straps move after boot; the choice must not follow
            pat_req <= ~bp;
            dbg_req <= ~ds;
            repeat (4) @(posedge SYS_CLK);
            check({BOOT_DOWNLOAD, DEBUG_FROM_USB, PIN_DEBUG_EN, USB_DEBUG_EN}, e);
            ahb(1'h0, 8'h04, 32'h0, rd);
            check(rd[6:0], {e[0], e[1], e[2], e[3], ds, bp});
        end
        wv = $urandom;
        ahb(1'h1, 8'h10, wv, rd);
        ahb(1'h0, 8'h10, 32'h0, rd);
        check(rd, wv);
        ahb(1'h0, 8'h20, 32'h0, rd);
        check(rd, 32'h0);
        // Twenty-four pin boots counted; power-on and pin causes stick
        ahb(1'h0, 8'h0C, 32'h0, rd);
        check(rd, 32'h00000018);
        ahb(1'h0, 8'h08, 32'h0, rd);
        check(rd, 32'h00000005);
        ahb(1'h1, 8'h08, 32'h00000007, rd);
        ahb(1'h0, 8'h08, 32'h0, rd);
        check(rd, 32'h0);
        // Live pads follow the moved straps while the latched choice stays
        ahb(1'h0, 8'h14, 32'h0, rd);
        check(rd, {29'h0, ~ds, (bp == 2'h3) ? 2'h3 : ~bp});
        // Soft reboot drops the core, restarts the stretch and recaptures
        ahb(1'h1, 8'h00, 32'h00000001, rd);
        repeat (2) @(posedge SYS_CLK);
        check(CORE_RST_N, 32'h0);
        repeat (8) @(posedge SYS_CLK);
        check(CORE_RST_N, 32'h1);
        e = expect_out((bp == 2'h3) ? 2'h3 : ~bp, ~ds, FUSE_USB_DEBUG_OFF, FUSE_PIN_DEBUG_OFF, FUSE_DEBUG_SELECT_ALLOW);
        check({BOOT_DOWNLOAD, DEBUG_FROM_USB, PIN_DEBUG_EN, USB_DEBUG_EN}, e);
        ahb(1'h0, 8'h08, 32'h0, rd);
        check(rd, 32'h00000002);
        ahb(1'h0, 8'h0C, 32'h0, rd);
        check(rd, 32'h00000019);
        // Hold bit keeps the core in reset until software clears it
        ahb(1'h1, 8'h00, 32'h00000002, rd);
        ahb(1'h0, 8'h00, 32'h0, rd);
        check(rd, 32'h00000002);
        check(CORE_RST_N, 32'h0);
        ahb(1'h1, 8'h00, 32'h0, rd);
        repeat (8) @(posedge SYS_CLK);
        check(CORE_RST_N, 32'h1);
        report_and_stop;
    end
endmodule // rbs_top_test
